// >>> hw/cfi_fifo_track.sv
// Occupancy tracker and flag source for one CAN message FIFO.
`timescale 1ns/1ns
module cfi_fifo_track (
   input  wire logic          clk,
   input  wire logic          srst,
   input  wire logic          is_tx,
   input  wire logic          push,
   input  wire logic          pop,
   input  wire logic          clr_ovr,
   output cfi_pkg::cfi_flags_t flags
);
   import cfi_pkg::*;

   // Whole state of the tracker.
   typedef struct packed {
      logic [CNT_W-1:0] count;
      logic             ovr;
   } cfi_track_t;

   cfi_track_t st_q;
   cfi_track_t st_d;
   logic       full;
   logic       take_push;
   logic       take_pop;
   logic       ovr_set;

   // Push is refused when full unless a pop frees a slot in the same cycle.
   assign full      = (st_q.count == CNT_FULL);
   assign take_pop  = pop && (st_q.count != CNT_ZERO);
   assign take_push = push && (!full || take_pop);
   assign ovr_set   = push && !take_push && !is_tx;

   // Next state: count moves, overflow set wins over a clear.
   always_comb begin
      st_d = st_q;
      if (take_push && !take_pop) begin
         st_d.count = st_q.count + CNT_ONE;
      end else if (take_pop && !take_push) begin
         st_d.count = st_q.count - CNT_ONE;
      end
      if (ovr_set) begin
         st_d.ovr = 1'b1;
      end else if (clr_ovr) begin
         st_d.ovr = 1'b0;
      end
   end

   // State register.
   always_ff @(posedge clk) begin
      if (srst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // Flags mirror the registered occupancy and the transmit or receive mode; rx_overrun mirrors the overflow bit in both modes.
   always_comb begin
      flags            = '0;
      flags.tx_space   = is_tx && !full;
      flags.tx_half    = is_tx && (st_q.count <= CNT_HALF);
      flags.tx_drained = is_tx && (st_q.count == CNT_ZERO);
      flags.rx_overrun = st_q.ovr;
      flags.rx_full    = !is_tx && full;
      flags.rx_half    = !is_tx && (st_q.count >= CNT_HALF);
      flags.rx_pending = !is_tx && (st_q.count != CNT_ZERO);
   end

endmodule : cfi_fifo_track

// >>> hw/cfi_pkg.sv
// Package with constants, field layouts, carriers and decoders for the CAN filter and FIFO block.
package cfi_pkg;

   // Sizes of the FIFO set and of the register port.
   localparam int          FIFO_N     = 32;
   localparam int          IDX_W      = 5;
   localparam int          ADDR_W     = 12;
   localparam int          DATA_W     = 32;
   localparam int          FIFO_DEPTH = 8;
   localparam int          CNT_W      = 4;
   localparam logic [3:0]  CNT_FULL   = 4'h8;
   localparam logic [3:0]  CNT_HALF   = 4'h4;
   localparam logic [3:0]  CNT_ZERO   = 4'h0;
   localparam logic [3:0]  CNT_ONE    = 4'h1;

   // Register byte addresses.
   localparam logic [11:0] OFF_FLTCON   = 12'h000;
   localparam logic [11:0] OFF_TXMODE   = 12'h004;
   localparam logic [11:0] OFF_EVT_STAT = 12'h008;
   localparam logic [11:0] OFF_EVT_MASK = 12'h00c;
   localparam logic [11:0] OFF_FIFOINT  = 12'h100;
   localparam logic [11:0] FIFOINT_MSK  = 12'hf80;

   // Filter control field positions.
   localparam int FLT13_LSB   = 8;
   localparam int FLT12_LSB   = 0;
   localparam int FLT_W       = 8;
   localparam int FLT_ON_BIT  = 7;
   localparam int FLT_MSK_HI  = 6;
   localparam int FLT_MSK_LO  = 5;
   localparam int FLT_DST_HI  = 4;
   localparam int FLT_DST_LO  = 0;

   // FIFO interrupt register bit positions.
   localparam int IE_TX_SPACE   = 26;
   localparam int IE_TX_HALF    = 25;
   localparam int IE_TX_DRAINED = 24;
   localparam int IE_RX_OVR     = 19;
   localparam int IE_RX_FULL    = 18;
   localparam int IE_RX_HALF    = 17;
   localparam int IE_RX_PEND    = 16;
   localparam int IF_TX_SPACE   = 10;
   localparam int IF_TX_HALF    = 9;
   localparam int IF_TX_DRAINED = 8;
   localparam int IF_RX_OVR     = 3;
   localparam int IF_RX_FULL    = 2;
   localparam int IF_RX_HALF    = 1;
   localparam int IF_RX_PEND    = 0;

   // One filter's control byte.
   typedef struct packed {
      logic             on;
      logic [1:0]       mask_choice;
      logic [IDX_W-1:0] dest_buffer;
   } cfi_filter_t;

   // Occupancy flags of one FIFO; the enable set uses the same order.
   typedef struct packed {
      logic tx_space;
      logic tx_half;
      logic tx_drained;
      logic rx_overrun;
      logic rx_full;
      logic rx_half;
      logic rx_pending;
   } cfi_flags_t;

   // Register port request.
   typedef struct packed {
      logic              we;
      logic              re;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } cfi_bus_req_t;

   // Outcome of the identifier comparators for one received message.
   typedef struct packed {
      logic valid;
      logic hit12;
      logic hit13;
   } cfi_msg_t;

   // A push or pop request aimed at one FIFO.
   typedef struct packed {
      logic             valid;
      logic [IDX_W-1:0] idx;
   } cfi_fifo_op_t;

   // Tells whether an address hits the FIFO interrupt array.
   function automatic logic fifoint_hit(input logic [ADDR_W-1:0] a);
      return ((a & FIFOINT_MSK) == OFF_FIFOINT) && (a[1:0] == 2'b00);
   endfunction : fifoint_hit

   // Gives the FIFO index of an address in the FIFO interrupt array.
   function automatic logic [IDX_W-1:0] fifoint_idx(input logic [ADDR_W-1:0] a);
      return a[IDX_W+1:2];
   endfunction : fifoint_idx

endpackage : cfi_pkg

// >>> hw/cfi_top.sv
// Filter control, FIFO interrupt registers and message routing for the CAN controller.
`timescale 1ns/1ns
module cfi_top (
   input  wire logic                  clk,
   input  wire logic                  srst,
   input  cfi_pkg::cfi_bus_req_t      bus_req,
   output logic [cfi_pkg::DATA_W-1:0] rd_data,
   input  cfi_pkg::cfi_msg_t          msg_in,
   input  cfi_pkg::cfi_fifo_op_t      tx_load,
   input  cfi_pkg::cfi_fifo_op_t      fifo_drain,
   output cfi_pkg::cfi_filter_t       filter_12,
   output cfi_pkg::cfi_filter_t       filter_13,
   output cfi_pkg::cfi_fifo_op_t      store,
   output logic [cfi_pkg::FIFO_N-1:0] fifo_irq,
   output logic                       irq
);
   import cfi_pkg::*;

   // Whole state of the block.
   typedef struct packed {
      cfi_filter_t                  f13;
      cfi_filter_t                  f12;
      logic [FIFO_N-1:0]            tx_mode;
      logic [FIFO_N-1:0][6:0]       ien;
      logic [FIFO_N-1:0]            evt_stat;
      logic [FIFO_N-1:0]            evt_mask;
      logic [FIFO_N-1:0]            req_prev;
      logic [DATA_W-1:0]            rdata;
      cfi_fifo_op_t                 store;
   } cfi_state_t;

   cfi_state_t             st_q;
   cfi_state_t             st_d;
   cfi_flags_t [FIFO_N-1:0] flags;
   logic [FIFO_N-1:0]      push_vec;
   logic [FIFO_N-1:0]      pop_vec;
   logic [FIFO_N-1:0]      clr_ovr_vec;
   logic [FIFO_N-1:0]      req_vec;
   logic                   wr_fltcon;
   logic                   wr_txmode;
   logic                   wr_mask;
   logic                   wr_fifoint;
   logic                   rd_stat;
   logic [IDX_W-1:0]       acc_idx;
   logic                   acc12;
   logic                   acc13;
   cfi_fifo_op_t           route;
   cfi_filter_t            new12;
   cfi_filter_t            new13;

   // Address decode of the register port.
   assign wr_fltcon  = bus_req.we && (bus_req.addr == OFF_FLTCON);
   assign wr_txmode  = bus_req.we && (bus_req.addr == OFF_TXMODE);
   assign wr_mask    = bus_req.we && (bus_req.addr == OFF_EVT_MASK);
   assign wr_fifoint = bus_req.we && fifoint_hit(bus_req.addr);
   assign rd_stat    = bus_req.re && (bus_req.addr == OFF_EVT_STAT);
   assign acc_idx    = fifoint_idx(bus_req.addr);

   // Field images of a filter control write.
   assign new12 = bus_req.wdata[FLT12_LSB +: FLT_W];
   assign new13 = bus_req.wdata[FLT13_LSB +: FLT_W];

   // Only enabled filters take part; filter 12 wins when both match.
   assign acc12 = msg_in.valid && msg_in.hit12 && st_q.f12.on;
   assign acc13 = msg_in.valid && msg_in.hit13 && st_q.f13.on;

   // Destination of the accepted message.
   always_comb begin
      route = '0;
      if (acc12) begin
         route.valid = 1'b1;
         route.idx   = st_q.f12.dest_buffer;
      end else if (acc13) begin
         route.valid = 1'b1;
         route.idx   = st_q.f13.dest_buffer;
      end
   end

   // One tracker per FIFO, each with its own slice of every request.
   genvar gi;
   generate
      for (gi = 0; gi < FIFO_N; gi++) begin : g_fifo
         assign push_vec[gi] = (route.valid && !st_q.tx_mode[gi] &&
                                (route.idx == IDX_W'(gi))) ||
                               (tx_load.valid && st_q.tx_mode[gi] &&
                                (tx_load.idx == IDX_W'(gi)));
         assign pop_vec[gi]  = fifo_drain.valid && (fifo_drain.idx == IDX_W'(gi));
         assign clr_ovr_vec[gi] = wr_fifoint && (acc_idx == IDX_W'(gi)) &&
                                  !bus_req.wdata[IF_RX_OVR];
         assign req_vec[gi]  = |(flags[gi] & cfi_flags_t'(st_q.ien[gi]));

         cfi_fifo_track u_track (
            .clk     (clk),
            .srst    (srst),
            .is_tx   (st_q.tx_mode[gi]),
            .push    (push_vec[gi]),
            .pop     (pop_vec[gi]),
            .clr_ovr (clr_ovr_vec[gi]),
            .flags   (flags[gi])
         );
      end
   endgenerate

   // Register writes, read data capture and event status.
   always_comb begin
      st_d       = st_q;
      st_d.store = route;
      st_d.rdata = '0;

      // Filter control: enables always write, other fields only while disabled.
      if (wr_fltcon) begin
         st_d.f12.on = new12.on;
         st_d.f13.on = new13.on;
         if (!st_q.f12.on) begin
            st_d.f12.mask_choice = new12.mask_choice;
            st_d.f12.dest_buffer = new12.dest_buffer;
         end
         if (!st_q.f13.on) begin
            st_d.f13.mask_choice = new13.mask_choice;
            st_d.f13.dest_buffer = new13.dest_buffer;
         end
      end

      if (wr_txmode) begin
         st_d.tx_mode = bus_req.wdata;
      end
      if (wr_mask) begin
         st_d.evt_mask = bus_req.wdata;
      end

      // Only the enable bits of a FIFO interrupt word store; a zero in the overflow flag bit clears the overflow, other flag bits ignore writes.
      if (wr_fifoint) begin
         st_d.ien[acc_idx] = {bus_req.wdata[IE_TX_SPACE],
                              bus_req.wdata[IE_TX_HALF],
                              bus_req.wdata[IE_TX_DRAINED],
                              bus_req.wdata[IE_RX_OVR],
                              bus_req.wdata[IE_RX_FULL],
                              bus_req.wdata[IE_RX_HALF],
                              bus_req.wdata[IE_RX_PEND]};
      end

      // A read of the status clears it, but a new rising request still sets.
      st_d.req_prev = req_vec;
      if (rd_stat) begin
         st_d.evt_stat = '0;
      end
      st_d.evt_stat = st_d.evt_stat | (req_vec & ~st_q.req_prev);

      // Read data, valid in the cycle after the strobe; unmapped reads give zero.
      if (bus_req.re) begin
         case (bus_req.addr)
            OFF_FLTCON: begin
               st_d.rdata[FLT12_LSB +: FLT_W] = st_q.f12;
               st_d.rdata[FLT13_LSB +: FLT_W] = st_q.f13;
            end
            OFF_TXMODE: begin
               st_d.rdata = st_q.tx_mode;
            end
            OFF_EVT_STAT: begin
               st_d.rdata = st_q.evt_stat;
            end
            OFF_EVT_MASK: begin
               st_d.rdata = st_q.evt_mask;
            end
            default: begin
               if (fifoint_hit(bus_req.addr)) begin
                  st_d.rdata = fifoint_word(st_q.ien[acc_idx], flags[acc_idx]);
               end
            end
         endcase
      end
   end

   // Packs one FIFO interrupt word; unimplemented bits read zero.
   function automatic logic [DATA_W-1:0] fifoint_word(input logic [6:0] en,
                                                      input cfi_flags_t fl);
      logic [DATA_W-1:0] w;
      cfi_flags_t        e;
      w = '0;
      e = cfi_flags_t'(en);
      w[IE_TX_SPACE]   = e.tx_space;
      w[IE_TX_HALF]    = e.tx_half;
      w[IE_TX_DRAINED] = e.tx_drained;
      w[IE_RX_OVR]     = e.rx_overrun;
      w[IE_RX_FULL]    = e.rx_full;
      w[IE_RX_HALF]    = e.rx_half;
      w[IE_RX_PEND]    = e.rx_pending;
      w[IF_TX_SPACE]   = fl.tx_space;
      w[IF_TX_HALF]    = fl.tx_half;
      w[IF_TX_DRAINED] = fl.tx_drained;
      w[IF_RX_OVR]     = fl.rx_overrun;
      w[IF_RX_FULL]    = fl.rx_full;
      w[IF_RX_HALF]    = fl.rx_half;
      w[IF_RX_PEND]    = fl.rx_pending;
      return w;
   endfunction : fifoint_word

   // State register with zero reset.
   always_ff @(posedge clk) begin
      if (srst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs.
   assign rd_data   = st_q.rdata;
   assign filter_12 = st_q.f12;
   assign filter_13 = st_q.f13;
   assign store     = st_q.store;
   assign fifo_irq  = req_vec;
   assign irq       = |(st_q.evt_stat & st_q.evt_mask);

endmodule : cfi_top

// >>> test/cfi_can_node.sv
// Behavioural model of the other CAN nodes that feed comparator results.
`timescale 1ns/1ns
module cfi_can_node (
   input  wire logic          clk,
   input  wire logic          srst,
   input  wire logic          send,
   input  wire logic          hit12,
   input  wire logic          hit13,
   output cfi_pkg::cfi_msg_t  msg
);
   import cfi_pkg::*;

   // One message per request; between messages the match lines toggle so stale hits never look valid.
   always_ff @(posedge clk) begin
      if (srst) begin
         msg <= '0;
      end else if (send) begin
         msg <= '{valid: 1'b1, hit12: hit12, hit13: hit13};
      end else begin
         msg <= '{valid: 1'b0, hit12: ~msg.hit12, hit13: ~msg.hit13};
      end
   end
endmodule : cfi_can_node

// >>> test/cfi_top_assertions.sv
// Assertion checker for the CAN filter and FIFO interrupt block.
`timescale 1ns/1ns
module cfi_top_assertions (
   input wire logic                  clk,
   input wire logic                  srst,
   input cfi_pkg::cfi_bus_req_t      bus_req,
   input logic [cfi_pkg::DATA_W-1:0] rd_data,
   input cfi_pkg::cfi_msg_t          msg_in,
   input cfi_pkg::cfi_fifo_op_t      tx_load,
   input cfi_pkg::cfi_fifo_op_t      fifo_drain,
   input cfi_pkg::cfi_filter_t       filter_12,
   input cfi_pkg::cfi_filter_t       filter_13,
   input cfi_pkg::cfi_fifo_op_t      store,
   input logic [cfi_pkg::FIFO_N-1:0] fifo_irq,
   input logic                       irq
);
   import cfi_pkg::*;
   logic [31:0] tx_q;
   logic [31:0] firq_q;
   logic [4:0]  idx_q;
   wire         acc12 = msg_in.valid && msg_in.hit12 && filter_12.on;
   wire         acc13 = msg_in.valid && msg_in.hit13 && filter_13.on;
   wire         rd_int = bus_req.re && bus_req.addr[11:7] == 5'h02 && bus_req.addr[1:0] == 2'h0;

   // Tracks the transmit mode word and the interrupt lines seen at each read.
   always_ff @(posedge clk) begin
      firq_q <= fifo_irq;
      idx_q  <= bus_req.addr[6:2];
      if (srst) begin
         tx_q <= 32'h0;
      end else if (bus_req.we && bus_req.addr == 12'h004) begin
         tx_q <= bus_req.wdata;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   a_no_accept: assert property (!acc12 && !acc13 |=> !store.valid)
      else $error("store without an enabled matching filter");
   a_dest_twelve: assert property (
      acc12 |=> store.valid && store.idx == $past(filter_12.dest_buffer))
      else $error("filter 12 message stored in wrong FIFO");
   a_dest_thirteen: assert property (
      acc13 && !acc12 |=> store.valid && store.idx == $past(filter_13.dest_buffer))
      else $error("filter 13 message stored in wrong FIFO");
   a_lock_twelve: assert property (filter_12.on |=> $stable(filter_12[6:0]))
      else $error("filter 12 fields changed while enabled");
   a_lock_thirteen: assert property (
      filter_13.on |=> $stable(filter_13[6:0]))
      else $error("filter 13 fields changed while enabled");
   a_filter_read: assert property (
      bus_req.re && bus_req.addr == 12'h000
      |=> rd_data == {16'h0, $past(filter_13), $past(filter_12)})
      else $error("filter control read mismatch");
   a_unused_zero: assert property (
      rd_int |=> (rd_data & 32'hf8f0f8f0) == 32'h0)
      else $error("unimplemented bits read nonzero");
   a_irq_gating: assert property (
      rd_int |=> firq_q[idx_q] == |(rd_data[26:16] & rd_data[10:0]))
      else $error("FIFO interrupt disagrees with flags and enables");
   a_rx_no_space: assert property (
      rd_int && !tx_q[bus_req.addr[6:2]] |=> !rd_data[10])
      else $error("receive FIFO shows transmit space flag");

   c_store: cover property (store.valid);
   c_irq: cover property (irq);
   c_locked_write: cover property (filter_13.on && bus_req.we);
endmodule : cfi_top_assertions

bind cfi_top cfi_top_assertions chk_u (.clk(clk), .srst(srst), .bus_req(bus_req),
   .rd_data(rd_data), .msg_in(msg_in), .tx_load(tx_load), .fifo_drain(fifo_drain),
   .filter_12(filter_12), .filter_13(filter_13), .store(store), .fifo_irq(fifo_irq), .irq(irq));

// >>> test/cfi_top_tb_top.sv
// Self-checking testbench for the CAN filter and FIFO interrupt block.
`timescale 1ns/1ns
module cfi_top_tb_top;
   import cfi_pkg::*;
   logic          clk = 1'b0;
   logic          srst = 1'b1;
   cfi_bus_req_t  bus_req = '0;
   logic [31:0]   rd_data;
   cfi_msg_t      msg_in;
   cfi_fifo_op_t  tx_load = '0;
   cfi_fifo_op_t  fifo_drain = '0;
   cfi_filter_t   filter_12;
   cfi_filter_t   filter_13;
   cfi_fifo_op_t  store;
   logic [31:0]   fifo_irq;
   logic          irq;
   logic          send = 1'b0;
   logic [1:0]    hits = 2'h0;
   int            failures = 0;
   int            samples_checked = 0;

   // Free-running 100 MHz clock.
   always #5 clk = ~clk;

   cfi_top dut_u (.clk(clk), .srst(srst), .bus_req(bus_req), .rd_data(rd_data), .msg_in(msg_in),
      .tx_load(tx_load), .fifo_drain(fifo_drain), .filter_12(filter_12), .filter_13(filter_13),
      .store(store), .fifo_irq(fifo_irq), .irq(irq));
   cfi_can_node node_u (.clk(clk), .srst(srst), .send(send), .hit12(hits[1]), .hit13(hits[0]),
      .msg(msg_in));

   // Counts a comparison and reports a mismatch at once.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // One-cycle register write.
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      bus_req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      bus_req <= '0;
   endtask : wr

   // One-cycle register read, judged in the cycle after the strobe.
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge clk);
      bus_req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 32'h0};
      @(posedge clk);
      bus_req <= '0;
      #1 chk(rd_data, exp);
   endtask : rd

   // Sends n messages; returns in the cycle where the last routing answer stands.
   task automatic send_msg(input logic [1:0] h, input int n);
      repeat (n) begin
         @(posedge clk);
         send <= 1'b1;
         hits <= h;
         @(posedge clk);
         send <= 1'b0;
         @(posedge clk);
         #1;
      end
   endtask : send_msg

   // Loads or drains one FIFO n times back to back.
   task automatic fifo_op(input logic load, input logic [4:0] i, input int n);
      repeat (n) begin
         @(posedge clk);
         if (load) tx_load <= '{valid: 1'b1, idx: i};
         else fifo_drain <= '{valid: 1'b1, idx: i};
      end
      @(posedge clk);
      tx_load <= '0;
      fifo_drain <= '0;
   endtask : fifo_op

   // Mask codes, enable bits and the write lock of both filters.
   task automatic test_filters();
      logic [15:0] v;
      for (int m = 0; m < 4; m++) begin
         v = {1'b0, 2'(m), 5'(31 - m), 1'b0, 2'(m), 5'(m)};
         wr(OFF_FLTCON, {16'h0, v});
         rd(OFF_FLTCON, {16'h0, v});
      end
      wr(OFF_FLTCON, 32'hbfc0);
      rd(OFF_FLTCON, 32'hbfc0);
      wr(OFF_FLTCON, 32'h1f1f);
      rd(OFF_FLTCON, 32'h3f40);
      wr(OFF_FLTCON, 32'h1f1f);
      rd(OFF_FLTCON, 32'h1f1f);
      wr(OFF_FLTCON, 32'h809f);
      // The filter outputs settle after the edge that takes the write.
      #1 chk(32'(filter_12), 32'h9f);
      chk(32'(filter_13), 32'h80);
   endtask : test_filters

   // Routing to the selected FIFO, priority and a disabled filter.
   task automatic test_route();
      send_msg(2'b10, 1);
      chk(32'(store), 32'h3f);
      send_msg(2'b01, 1);
      chk(32'(store), 32'h20);
      send_msg(2'b11, 1);
      chk(32'(store), 32'h3f);
      wr(OFF_FLTCON, 32'h009f);
      send_msg(2'b01, 1);
      chk(32'(store.valid), 32'h0);
   endtask : test_route

   // Reset enables, not-empty interrupt, sticky status and its clear by read.
   task automatic test_irq();
      rd(12'h100, 32'h1);
      rd(12'h178, 32'h0);
      wr(12'h080, 32'hffffffff);
      rd(12'h080, 32'h0);
      wr(OFF_EVT_MASK, 32'h80000000);
      wr(12'h17c, 32'h00010000);
      repeat (2) @(posedge clk);
      #1 chk(32'(irq), 32'h1);
      rd(12'h17c, 32'h00010001);
      rd(OFF_EVT_STAT, 32'h80000000);
      repeat (2) @(posedge clk);
      #1 chk(32'(irq), 32'h0);
      fifo_op(1'b0, 5'd31, 2);
      #1 chk(32'(fifo_irq[31]), 32'h0);
   endtask : test_irq

   // Fill to full, overflow, read-only flags and the overflow clear.
   task automatic test_overflow();
      wr(12'h17c, 32'h000f0000);
      send_msg(2'b10, 8);
      rd(12'h17c, 32'h000f0007);
      send_msg(2'b10, 1);
      rd(12'h17c, 32'h000f000f);
      wr(12'h17c, 32'h000f07ff);
      rd(12'h17c, 32'h000f000f);
      wr(12'h17c, 32'h000f0000);
      rd(12'h17c, 32'h000f0007);
      fifo_op(1'b0, 5'd31, 8);
      rd(12'h17c, 32'h000f0000);
   endtask : test_overflow

   // Transmit space flag of a transmit FIFO from empty to full and back to one free slot.
   task automatic test_tx();
      wr(OFF_TXMODE, 32'h20);
      // An empty transmit FIFO shows space, half and drained together.
      rd(12'h114, 32'h700);
      fifo_op(1'b1, 5'd5, 9);
      rd(12'h114, 32'h0);
      fifo_op(1'b0, 5'd5, 1);
      rd(12'h114, 32'h400);
   endtask : test_tx

   // Prints the verdict and ends the run.
   task automatic complete_run();
      if (failures == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : complete_run

   // Main sequence after an eight-cycle reset.
   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      test_filters();
      test_route();
      test_irq();
      test_overflow();
      test_tx();
      complete_run();
   end

   // Watchdog against a hang.
   initial begin
      #100000;
      failures++;
      complete_run();
   end
endmodule : cfi_top_tb_top
